/* File: shared/tpwm_consts.vh */
// Constants for the triggered PWM timer: register offsets, field positions, reset values.
// Included by the timer, its monitor and its test bench; definitions only.
`ifndef TPWM_CONSTS_VH
`define TPWM_CONSTS_VH

`define OFS_EVENT_EDGE_SELECT   6'h00
`define OFS_COUNTER_SNAPSHOT    6'h04
`define OFS_PERIOD_COMPARE      6'h08
`define OFS_DUTY_COMPARE_ONE    6'h0C
`define OFS_DUTY_COMPARE_TWO    6'h10
`define OFS_DUTY_COMPARE_THREE  6'h14
`define OFS_CONTROL             6'h18
`define OFS_STATUS              6'h1C

`define EDGE_SEL_LO_BIT         2
`define EDGE_SEL_HI_BIT         3
`define EDGE_SEL_MASK           8'h0C

`define CTRL_RUN_BIT            0
`define CTRL_TRIG_BIT           1
`define CTRL_PRESCALE_LSB       8
`define CTRL_PRESCALE_MSB       15

`define RST_COMPARE             16'hFFFF
`define RST_COUNTER             16'hFFFF
`define RST_PRESCALE            8'h00

`endif

/* File: rtl/pwm_channel.v */
// One PWM channel: compares the running count against its duty buffer.
// Assumes count_tick marks the count-clock edge and restart marks a trigger.
`timescale 1ns/10ps

module pwm_channel #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             nrst,
    // Count state
    input  wire             running,
    input  wire             count_tick,
    input  wire             restart,
    input  wire             period_wrap,
    input  wire [WIDTH-1:0] count,
    input  wire [WIDTH-1:0] duty_buf,
    // Outputs
    output reg              pwm_q,
    output reg              irq_q
);

    wire             match_now;
    wire [WIDTH-1:0] count_next;

    // Value the counter takes at this tick; a wrap clears it to zero
    assign count_next = period_wrap ? {WIDTH{1'b0}} : count + 1'b1;
    // Match as the counter reaches the buffer value, compared against the value it takes at this tick
    assign match_now = running && count_tick && (count_next == duty_buf);

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pwm_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (!running) begin
            pwm_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (restart) begin
            // Trigger wins over a coincident duty match; a zero duty keeps 0%
            pwm_q <= (duty_buf != {WIDTH{1'b0}});
            irq_q <= 1'b0;
        end else begin
            irq_q <= match_now;
            if (period_wrap) begin
                // Zero duty matches at the wrap itself, so the output never rises
                pwm_q <= (duty_buf != {WIDTH{1'b0}});
            end else if (match_now) begin
                pwm_q <= 1'b0;
            end
        end
    end

endmodule // pwm_channel

/* File: rtl/triggered_pwm_timer.v */
// Triggered PWM timer: 16-bit counter restarted by a software trigger, three PWM outputs.
// Assumes a classic Wishbone master on the system clock; no interrupt controller here.
`timescale 1ns/10ps
`include "tpwm_consts.vh"

module triggered_pwm_timer #(
    parameter WIDTH    = 16,
    parameter PS_WIDTH = 8
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        nrst,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Timer outputs
    output reg         period_toggle_out,
    output wire        pwm_out_one,
    output wire        pwm_out_two,
    output wire        pwm_out_three,
    output reg         period_match_irq,
    output wire        duty_match_irq_one,
    output wire        duty_match_irq_two,
    output wire        duty_match_irq_three
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_RUN  = 3'b100;

    reg  [2:0]          state_q;
    reg  [7:0]          event_edge_select_q;
    reg  [WIDTH-1:0]    period_compare_q;
    reg  [WIDTH-1:0]    duty_compare_one_q;
    reg  [WIDTH-1:0]    duty_compare_two_q;
    reg  [WIDTH-1:0]    duty_compare_three_q;
    reg  [WIDTH-1:0]    period_buffer_q;
    reg  [WIDTH-1:0]    duty_buffer_one_q;
    reg  [WIDTH-1:0]    duty_buffer_two_q;
    reg  [WIDTH-1:0]    duty_buffer_three_q;
    reg  [WIDTH-1:0]    count_q;
    reg                 count_run_enable_q;
    reg                 transfer_armed_q;
    reg  [PS_WIDTH-1:0] prescale_q;
    reg  [PS_WIDTH-1:0] ps_cnt_q;
    reg                 wrap_seen_q;

    wire                wb_req;
    wire                wb_wr;
    wire                wb_lo;
    wire                wb_hi;
    wire                soft_trigger_bit;
    wire                running;
    wire                count_tick;
    wire                restart;
    wire                period_wrap;
    wire                duty_one_write;
    wire [31:0]         status_word;
    reg  [31:0]         rd_mux;
    wire                chan_active;
    wire                load_wrap;
    wire                load_now;
    wire [WIDTH-1:0]    duty_one_eff;
    wire [WIDTH-1:0]    duty_two_eff;
    wire [WIDTH-1:0]    duty_three_eff;

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr   = wb_req && wb_we_i;
    assign wb_lo   = wb_sel_i[0];
    assign wb_hi   = wb_sel_i[1];
    // Trigger is a write-one strobe of the control register; reads back as zero
    assign soft_trigger_bit = wb_wr && (wb_adr_i == `OFS_CONTROL) && wb_lo
                              && wb_dat_i[`CTRL_TRIG_BIT];
    assign running  = (state_q == ST_RUN);
    // A prescale lowered mid-count must not leave the divider stuck above it
    assign count_tick = running && (ps_cnt_q >= prescale_q);
    assign restart  = count_run_enable_q && soft_trigger_bit;
    // Clear happens on the count after the period match
    assign period_wrap = count_tick && (count_q == period_buffer_q) && !restart;
    assign duty_one_write = wb_wr && (wb_adr_i == `OFS_DUTY_COMPARE_ONE) && (wb_lo || wb_hi);

    // Channels hold their level while waiting, so the first trigger can raise them
    assign chan_active = count_run_enable_q && (state_q != ST_IDLE);
    // On a load edge the channels must see the incoming duty, not the outgoing one;
    // otherwise a zero-to-nonzero change would lose the first active phase
    assign load_wrap = period_wrap && transfer_armed_q && !duty_one_write;
    assign load_now  = ((state_q == ST_WAIT) && restart) || load_wrap;
    assign duty_one_eff   = load_now ? duty_compare_one_q   : duty_buffer_one_q;
    assign duty_two_eff   = load_now ? duty_compare_two_q   : duty_buffer_two_q;
    assign duty_three_eff = load_now ? duty_compare_three_q : duty_buffer_three_q;

    // Sequencer: idle until enabled, wait for a trigger, then run
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (count_run_enable_q) state_q <= ST_WAIT;
                ST_WAIT: begin
                    if (!count_run_enable_q) state_q <= ST_IDLE;
                    else if (restart) state_q <= ST_RUN;
                end
                ST_RUN:  if (!count_run_enable_q) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Count-clock divider; zero prescale counts every system clock
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ps_cnt_q <= {PS_WIDTH{1'b0}};
        end else if (!running || restart || count_tick) begin
            ps_cnt_q <= {PS_WIDTH{1'b0}};
        end else begin
            ps_cnt_q <= ps_cnt_q + 1'b1;
        end
    end

    // Counter, buffers and period outputs
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count_q             <= `RST_COUNTER;
            period_buffer_q     <= `RST_COMPARE;
            duty_buffer_one_q   <= `RST_COMPARE;
            duty_buffer_two_q   <= `RST_COMPARE;
            duty_buffer_three_q <= `RST_COMPARE;
            transfer_armed_q    <= 1'b0;
            period_toggle_out   <= 1'b0;
            period_match_irq    <= 1'b0;
            wrap_seen_q         <= 1'b0;
        end else begin
            period_match_irq <= 1'b0;
            if (duty_one_write) begin
                transfer_armed_q <= 1'b1;
            end
            if (!count_run_enable_q) begin
                count_q           <= `RST_COUNTER;
                period_toggle_out <= 1'b0;
                wrap_seen_q       <= 1'b0;
            end else if (state_q == ST_WAIT && restart) begin
                // First start loads every buffer straight from its register
                count_q             <= {WIDTH{1'b0}};
                period_buffer_q     <= period_compare_q;
                duty_buffer_one_q   <= duty_compare_one_q;
                duty_buffer_two_q   <= duty_compare_two_q;
                duty_buffer_three_q <= duty_compare_three_q;
                transfer_armed_q    <= 1'b0;
                period_toggle_out   <= 1'b0;
            end else if (restart) begin
                count_q           <= {WIDTH{1'b0}};
                period_toggle_out <= ~period_toggle_out;
            end else if (period_wrap) begin
                count_q           <= {WIDTH{1'b0}};
                period_match_irq  <= 1'b1;
                period_toggle_out <= ~period_toggle_out;
                wrap_seen_q       <= 1'b1;
                if (transfer_armed_q && !duty_one_write) begin
                    period_buffer_q     <= period_compare_q;
                    duty_buffer_one_q   <= duty_compare_one_q;
                    duty_buffer_two_q   <= duty_compare_two_q;
                    duty_buffer_three_q <= duty_compare_three_q;
                    transfer_armed_q    <= 1'b0;
                end
            end else if (count_tick) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    pwm_channel #(.WIDTH(WIDTH)) u_ch_one (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .running     (chan_active),
        .count_tick  (count_tick),
        .restart     (restart),
        .period_wrap (period_wrap),
        .count       (count_q),
        .duty_buf    (duty_one_eff),
        .pwm_q       (pwm_out_one),
        .irq_q       (duty_match_irq_one)
    );

    pwm_channel #(.WIDTH(WIDTH)) u_ch_two (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .running     (chan_active),
        .count_tick  (count_tick),
        .restart     (restart),
        .period_wrap (period_wrap),
        .count       (count_q),
        .duty_buf    (duty_two_eff),
        .pwm_q       (pwm_out_two),
        .irq_q       (duty_match_irq_two)
    );

    pwm_channel #(.WIDTH(WIDTH)) u_ch_three (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .running     (chan_active),
        .count_tick  (count_tick),
        .restart     (restart),
        .period_wrap (period_wrap),
        .count       (count_q),
        .duty_buf    (duty_three_eff),
        .pwm_q       (pwm_out_three),
        .irq_q       (duty_match_irq_three)
    );

    // Register writes; byte lanes 0 and 1 carry the 16-bit compare values
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            event_edge_select_q  <= 8'h00;
            period_compare_q     <= `RST_COMPARE;
            duty_compare_one_q   <= `RST_COMPARE;
            duty_compare_two_q   <= `RST_COMPARE;
            duty_compare_three_q <= `RST_COMPARE;
            count_run_enable_q   <= 1'b0;
            prescale_q           <= `RST_PRESCALE;
        end else if (wb_wr) begin
            case (wb_adr_i)
                `OFS_EVENT_EDGE_SELECT: begin
                    if (wb_lo) event_edge_select_q <= wb_dat_i[7:0] & `EDGE_SEL_MASK;
                end
                `OFS_PERIOD_COMPARE: begin
                    if (wb_lo) period_compare_q[7:0]  <= wb_dat_i[7:0];
                    if (wb_hi) period_compare_q[15:8] <= wb_dat_i[15:8];
                end
                `OFS_DUTY_COMPARE_ONE: begin
                    if (wb_lo) duty_compare_one_q[7:0]  <= wb_dat_i[7:0];
                    if (wb_hi) duty_compare_one_q[15:8] <= wb_dat_i[15:8];
                end
                `OFS_DUTY_COMPARE_TWO: begin
                    if (wb_lo) duty_compare_two_q[7:0]  <= wb_dat_i[7:0];
                    if (wb_hi) duty_compare_two_q[15:8] <= wb_dat_i[15:8];
                end
                `OFS_DUTY_COMPARE_THREE: begin
                    if (wb_lo) duty_compare_three_q[7:0]  <= wb_dat_i[7:0];
                    if (wb_hi) duty_compare_three_q[15:8] <= wb_dat_i[15:8];
                end
                `OFS_CONTROL: begin
                    if (wb_lo) count_run_enable_q <= wb_dat_i[`CTRL_RUN_BIT];
                    if (wb_hi) prescale_q <= wb_dat_i[`CTRL_PRESCALE_MSB:`CTRL_PRESCALE_LSB];
                end
                default: ;
            endcase
        end
    end

    assign status_word = {28'h0000000, wrap_seen_q, transfer_armed_q,
                          running, (state_q == ST_WAIT)};

    // Read mux; unmapped offsets read zero and still acknowledge
    always @* begin
        case (wb_adr_i)
            `OFS_EVENT_EDGE_SELECT:  rd_mux = {24'h000000, event_edge_select_q};
            `OFS_COUNTER_SNAPSHOT:   rd_mux = {16'h0000, count_q};
            `OFS_PERIOD_COMPARE:     rd_mux = {16'h0000, period_compare_q};
            `OFS_DUTY_COMPARE_ONE:   rd_mux = {16'h0000, duty_compare_one_q};
            `OFS_DUTY_COMPARE_TWO:   rd_mux = {16'h0000, duty_compare_two_q};
            `OFS_DUTY_COMPARE_THREE: rd_mux = {16'h0000, duty_compare_three_q};
            `OFS_CONTROL:            rd_mux = {16'h0000, prescale_q, 7'h00, count_run_enable_q};
            `OFS_STATUS:             rd_mux = status_word;
            default:                 rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

endmodule // triggered_pwm_timer

/* File: sim/triggered_pwm_timer_monitor.sv */
// Port checker for the triggered PWM timer.
// Assumes it is bound into triggered_pwm_timer and sees only its ports.
`timescale 1ns/10ps
`include "tpwm_consts.vh"
module triggered_pwm_timer_monitor (
    // Clock and reset
    input wire        clk_sys,
    input wire        nrst,
    // Bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [5:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Timer outputs
    input wire        period_toggle_out,
    input wire        pwm_out_one,
    input wire        pwm_out_two,
    input wire        pwm_out_three,
    input wire        period_match_irq,
    input wire        duty_match_irq_one,
    input wire        duty_match_irq_two,
    input wire        duty_match_irq_three
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // A control write is the only way software can restart or stop the outputs
    wire ctl_wr = wb_ack_o && wb_we_i && (wb_adr_i == `OFS_CONTROL);
    // Trigger write being taken at this edge
    wire trig_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                    && (wb_adr_i == `OFS_CONTROL) && wb_dat_i[`CTRL_TRIG_BIT];

    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    edge_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `OFS_EVENT_EDGE_SELECT
        |-> (wb_dat_o & ~{24'h000000, `EDGE_SEL_MASK}) == 32'h00000000)
        else $error("edge select reads nonzero outside its field");
    irq_pulse_a: assert property (period_match_irq |=> !period_match_irq)
        else $error("period interrupt longer than one cycle");
    wrap_toggle_a: assert property (period_match_irq |-> period_toggle_out != $past(period_toggle_out))
        else $error("period interrupt without reference toggle");
    toggle_cause_a: assert property ($changed(period_toggle_out)
        |-> period_match_irq || ctl_wr || (!period_toggle_out && $past(ctl_wr)))
        else $error("reference toggled without wrap or trigger");
    duty_fall_a: assert property (duty_match_irq_one |-> !pwm_out_one)
        else $error("duty one interrupt not aligned with output change");
    duty_three_a: assert property (duty_match_irq_three |-> !pwm_out_three)
        else $error("duty three interrupt not aligned with output change");
    pwm_fall_a: assert property ($fell(pwm_out_one) |-> duty_match_irq_one || $past(ctl_wr))
        else $error("output one fell without duty match");
    pwm_rise_a: assert property ($rose(pwm_out_one) |-> period_match_irq || ctl_wr)
        else $error("output one rose without wrap or trigger");
    trig_period_a: assert property (trig_req |=> !period_match_irq)
        else $error("period interrupt raised on a trigger edge");
    trig_duty_a: assert property (trig_req
        |=> !duty_match_irq_one && !duty_match_irq_two && !duty_match_irq_three)
        else $error("duty interrupt raised on a trigger edge");
endmodule // triggered_pwm_timer_monitor

/* File: sim/triggered_pwm_timer_test.sv */
// Self-checking bench for the triggered PWM timer: registers, widths, transfer, restart, stop.
// Assumes the design files and tpwm_consts.vh are on the include path.
`timescale 1ns/10ps
`include "tpwm_consts.vh"
module triggered_pwm_timer_test;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [5:0]  wb_adr_i = 6'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, period_toggle_out, pwm_out_one, pwm_out_two, pwm_out_three;
    wire         period_match_irq, duty_match_irq_one, duty_match_irq_two, duty_match_irq_three;
    int          bad_count = 0;
    int          checks = 0;
    int          cycles = 0;
    int          len, h1, h2, h3, n1, n2, n3, c;
    logic [31:0] rd, r;
    logic [15:0] p, d1, d2, d3, np, nd2;
    logic [7:0]  ps;

    always #2.5 clk_sys = ~clk_sys;

    triggered_pwm_timer i_triggered_pwm_timer (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .period_toggle_out, .pwm_out_one,
        .pwm_out_two, .pwm_out_three, .period_match_irq, .duty_match_irq_one,
        .duty_match_irq_two, .duty_match_irq_three);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang anywhere counts against the run instead of stalling it
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; the leading edge keeps strobe low a cycle between requests
    task automatic wb(input logic we, input logic [5:0] adr, input logic [15:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        // Ack and read data are taken at the rising edge that samples ack high
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    function automatic int ticks(input int v);
        return v * (ps + 1);
    endfunction

    task automatic wait_wrap();
        @(negedge clk_sys);
        while (period_match_irq !== 1'b1) @(negedge clk_sys);
    endtask

    // Counts one whole period from one wrap to the next
    task automatic chk_wave();
        wait_wrap();
        {len, h1, h2, h3, n1, n2, n3} = '0;
        do begin
            len++;
            h1 += pwm_out_one;
            h2 += pwm_out_two;
            h3 += pwm_out_three;
            n1 += duty_match_irq_one;
            n2 += duty_match_irq_two;
            n3 += duty_match_irq_three;
            @(negedge clk_sys);
        end while (period_match_irq !== 1'b1);
        chk("period_len", len, ticks(p + 1));
        chk("width_one", h1, ticks(d1));
        chk("width_two", h2, ticks(d2));
        chk("width_three", h3, ticks(d3));
    endtask

    initial begin
        r = $urandom(36);
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 8; a <= 20; a += 4) begin
            wb(1'b0, 6'(a), 16'h0000);
            chk("compare_reset", rd, 32'h0000FFFF);
        end
        wb(1'b0, `OFS_COUNTER_SNAPSHOT, 16'h0000);
        chk("count_idle", rd, 32'h0000FFFF);
        r = $urandom;
        wb(1'b1, `OFS_EVENT_EDGE_SELECT, r[15:0]);
        wb(1'b0, `OFS_EVENT_EDGE_SELECT, 16'h0000);
        chk("edge_field", rd, {24'h000000, r[7:0] & `EDGE_SEL_MASK});
        wb(1'b1, 6'h20, 16'h1234);
        wb(1'b0, 6'h20, 16'h0000);
        chk("unmapped", rd, 32'h00000000);
        chk("idle_out", pwm_out_one, 1'b0);
        $display("test registers done");
        ps = 8'($urandom_range(1, 0));
        p = 16'($urandom_range(15, 8));
        d1 = 16'($urandom_range(p, 1));
        d2 = 16'h0000;
        d3 = p + 16'h0001;
        wb(1'b1, `OFS_PERIOD_COMPARE, p);
        wb(1'b1, `OFS_DUTY_COMPARE_TWO, d2);
        wb(1'b1, `OFS_DUTY_COMPARE_THREE, d3);
        wb(1'b1, `OFS_DUTY_COMPARE_ONE, d1);
        wb(1'b1, `OFS_CONTROL, {ps, 8'h01});
        wb(1'b1, `OFS_CONTROL, {ps, 8'h03});
        chk_wave();
        chk_wave();
        chk("irq_counts", {n1[3:0], n2[3:0], n3[3:0]}, 12'h110);
        wb(1'b0, `OFS_COUNTER_SNAPSHOT, 16'h0000);
        chk("count_run", rd <= p, 1'b1);
        $display("test widths done");
        np = 16'($urandom_range(15, 8));
        nd2 = 16'($urandom_range(np, 1));
        wb(1'b1, `OFS_PERIOD_COMPARE, np);
        wb(1'b1, `OFS_DUTY_COMPARE_TWO, nd2);
        wb(1'b0, `OFS_STATUS, 16'h0000);
        chk("unarmed", rd[2], 1'b0);
        chk_wave();
        p = np;
        d2 = nd2;
        d3 = np + 16'h0001;
        d1 = 16'($urandom_range(np, 1));
        wb(1'b1, `OFS_DUTY_COMPARE_THREE, d3);
        wb(1'b1, `OFS_DUTY_COMPARE_ONE, d1);
        // A duty one write landing on a wrap defers the transfer by one period
        wait_wrap();
        chk_wave();
        $display("test transfer done");
        ps = 8'h00;
        wb(1'b1, `OFS_CONTROL, 16'h0001);
        // Offsets straddle the wrap so triggers land before, on and after it
        for (int k = -3; k <= 1; k++) begin
            wait_wrap();
            repeat (int'(p) + k) @(negedge clk_sys);
            wb(1'b1, `OFS_CONTROL, 16'h0003);
            @(negedge clk_sys);
            // One tick has passed since the trigger, so a duty of one has already ended
            chk("trig_out", {pwm_out_one, pwm_out_two, pwm_out_three}, {d1 > 16'h0001, d2 > 16'h0001, 1'b1});
            c = 0;
            while (period_match_irq !== 1'b1) begin
                @(negedge clk_sys);
                c++;
            end
            chk("trig_len", c, p);
        end
        $display("test trigger done");
        wb(1'b1, `OFS_CONTROL, 16'h0000);
        repeat (2) @(negedge clk_sys);
        n1 = 0;
        repeat (40) begin
            @(negedge clk_sys);
            n1 += period_match_irq | duty_match_irq_one | pwm_out_one | pwm_out_two
                  | pwm_out_three | period_toggle_out;
        end
        chk("stopped_quiet", n1, 0);
        wb(1'b0, `OFS_COUNTER_SNAPSHOT, 16'h0000);
        chk("count_stop", rd, 32'h0000FFFF);
        $display("test stop done");
        end_of_test();
    end
endmodule // triggered_pwm_timer_test

bind triggered_pwm_timer triggered_pwm_timer_monitor i_triggered_pwm_timer_monitor (.clk_sys,
    .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .period_toggle_out, .pwm_out_one, .pwm_out_two, .pwm_out_three, .period_match_irq,
    .duty_match_irq_one, .duty_match_irq_two, .duty_match_irq_three);
